// ===== include/edge_if.sv
// synchronised level and edge strobes of one outside input
`timescale 1ns/1ps
interface edge_if;
    logic level;
    logic rise;
    logic fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// ===== include/pqc_pkg.sv
// shared constants and types for the period and quadrature counter
package pqc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int COUNT_W = 32;
    localparam int SYNC_N = 6;

    // ------------------------------------------------------------
    // synchronised input slots
    // ------------------------------------------------------------
    localparam int IN_A = 0;
    localparam int IN_B = 1;
    localparam int IN_Z = 2;
    localparam int IN_GATE = 3;
    localparam int IN_SOURCE = 4;
    localparam int IN_SAMPLE = 5;

    // ------------------------------------------------------------
    // reset and step values
    // ------------------------------------------------------------
    localparam logic [COUNT_W-1:0] COUNT_RST = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;

    // ------------------------------------------------------------
    // decoding modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEC_X1 = 2'h0,
        DEC_X2 = 2'h1,
        DEC_X4 = 2'h2,
        DEC_TWO_PULSE = 2'h3
    } decode_mode_t;

    // ------------------------------------------------------------
    // reload phases, numbered in forward quadrature order a0b0, a1b0, a1b1, a0b1
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_A0_B0 = 2'h0,
        PH_A1_B0 = 2'h1,
        PH_A1_B1 = 2'h2,
        PH_A0_B1 = 2'h3
    } reload_phase_t;

    // ------------------------------------------------------------
    // period measurement states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PER_IDLE = 4'h1,
        PER_WAIT_OPEN = 4'h2,
        PER_COUNT = 4'h4,
        PER_DONE = 4'h8
    } period_state_t;

endpackage

// ===== logic/input_sync.sv
// three-stage synchroniser with agreement filter and edge strobes
`timescale 1ns/1ps
module input_sync (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic pin_i,
    edge_if.src sig
);

    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic agree;

    // ------------------------------------------------------------
    // synchroniser chain
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    // a change is accepted only when stages two and three agree
    assign agree = (s2_q == s3_q);

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            level_q <= 1'b0;
        end else if (agree) begin
            level_q <= s3_q;
        end
    end

    // one strobe per accepted change
    assign sig.level = level_q;
    assign sig.rise = agree && s3_q && !level_q;
    assign sig.fall = agree && !s3_q && level_q;

endmodule

// ===== logic/period_quad_counter.sv
// period measurement and quadrature position counter, top level
//
// Overview of operation
// - period measured once, only after arming
// - gate period edges: rising or falling
// - count source edges between gate edges
// - position counts only after arm
// - on-demand read or sample-clocked read
// - inputs: phase a, phase b, index z
// - x1: a leads, up on a rise
// - x1: b leads, down on a fall
// - x2: step on both a edges
// - x4: step on all a, b edges
// - two-pulse encoder mode supported
// - two-pulse: a rise up, b rise down
// - z high in chosen phase reloads count
// - step wins, a reload in that cycle is dropped
`timescale 1ns/1ps
module period_quad_counter (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_z_i,
    input wire logic gate_i,
    input wire logic source_i,
    input wire logic sample_clk_i,
    input wire logic arm_i,
    input wire logic disarm_i,
    input wire logic position_sel_i,
    input wire logic gate_rising_i,
    input wire logic source_rising_i,
    input wire pqc_pkg::decode_mode_t decode_mode_i,
    input wire logic reload_en_i,
    input wire pqc_pkg::reload_phase_t reload_phase_i,
    input wire logic [31:0] reload_value_i,
    input wire logic buffered_i,
    input wire logic sample_rising_i,
    input wire logic read_req_i,
    output logic armed_o,
    output logic period_busy_o,
    output logic [31:0] period_o,
    output logic period_valid_o,
    output logic [31:0] position_o,
    output logic [31:0] sample_o,
    output logic sample_valid_o
);

    // ------------------------------------------------------------
    // usage notes
    // ------------------------------------------------------------
    // pins are asynchronous; a level must hold two clocks to be seen
    // a, b, gate and source edges reach the counters three to four clocks late, z four to five
    // the period and position counts wrap silently past all ones
    // a disarm aborts a period measurement and leaves no result
    // arm and disarm in one cycle: the arm wins
    // the sample clock pin is seen like any other pin, so it must
    // stay below a quarter of the clock rate to keep every edge

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // one level and edge carrier per outside pin
    edge_if sync_bus [pqc_pkg::SYNC_N] ();
    logic [pqc_pkg::SYNC_N-1:0] pins;

    // all encoder, gate, source and sample lines
    assign pins = {sample_clk_i, source_i, gate_i, enc_z_i, enc_b_i, enc_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < pqc_pkg::SYNC_N; gi++) begin : g_sync
            // each pin is resynchronised before edge detection
            input_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .pin_i(pins[gi]),
                .sig(sync_bus[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // edge selection
    // ------------------------------------------------------------
    logic gate_edge;
    logic source_edge;
    logic sample_edge;
    logic z_level;
    logic a_level;
    logic b_level;

    assign gate_edge = gate_rising_i ? sync_bus[pqc_pkg::IN_GATE].rise
                                     : sync_bus[pqc_pkg::IN_GATE].fall;
    // the chosen source polarity is what the period count sees
    assign source_edge = source_rising_i ? sync_bus[pqc_pkg::IN_SOURCE].rise
                                         : sync_bus[pqc_pkg::IN_SOURCE].fall;
    // the sample clock polarity is followed live, not latched at the arm
    assign sample_edge = sample_rising_i ? sync_bus[pqc_pkg::IN_SAMPLE].rise
                                         : sync_bus[pqc_pkg::IN_SAMPLE].fall;
    // settled levels feed the reload phase match
    assign z_level = sync_bus[pqc_pkg::IN_Z].level;
    assign a_level = sync_bus[pqc_pkg::IN_A].level;
    assign b_level = sync_bus[pqc_pkg::IN_B].level;

    // ------------------------------------------------------------
    // quadrature decoding
    // ------------------------------------------------------------
    logic step_up;
    logic step_dn;

    quad_decoder u_dec (
        .mode_i(decode_mode_i),
        .a(sync_bus[pqc_pkg::IN_A]),
        .b(sync_bus[pqc_pkg::IN_B]),
        .step_up_o(step_up),
        .step_dn_o(step_dn)
    );

    // ------------------------------------------------------------
    // arming
    // ------------------------------------------------------------
    logic armed_q;
    logic pos_mode_q;
    logic period_finish;

    // arm wins over disarm; the mode is latched at the arm
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            armed_q <= 1'b0;
            pos_mode_q <= 1'b0;
        end else if (arm_i) begin
            armed_q <= 1'b1;
            pos_mode_q <= position_sel_i;
        end else if (disarm_i || period_finish) begin
            armed_q <= 1'b0;
        end
    end

    assign armed_o = armed_q;

    // ------------------------------------------------------------
    // period measurement state machine
    // ------------------------------------------------------------
    pqc_pkg::period_state_t per_state_q;
    logic [31:0] per_count_q;
    logic [31:0] period_q;
    logic period_valid_q;

    // the closing gate edge ends the single measurement
    assign period_finish = (per_state_q == pqc_pkg::PER_COUNT) && gate_edge;

    // waits for the opening gate edge, counts, closes on the next one
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            per_state_q <= pqc_pkg::PER_IDLE;
        end else if (arm_i) begin
            // arm beats a disarm in the same cycle, as the arming flag does
            per_state_q <= position_sel_i ? pqc_pkg::PER_IDLE
                                          : pqc_pkg::PER_WAIT_OPEN;
        end else if (disarm_i) begin
            per_state_q <= pqc_pkg::PER_IDLE;
        end else begin
            case (per_state_q)
                pqc_pkg::PER_IDLE: begin
                    per_state_q <= pqc_pkg::PER_IDLE;
                end
                pqc_pkg::PER_WAIT_OPEN: begin
                    if (gate_edge) begin
                        per_state_q <= pqc_pkg::PER_COUNT;
                    end
                end
                pqc_pkg::PER_COUNT: begin
                    if (gate_edge) begin
                        per_state_q <= pqc_pkg::PER_DONE; // one period only
                    end
                end
                pqc_pkg::PER_DONE: begin
                    per_state_q <= pqc_pkg::PER_DONE;
                end
                default: begin
                    per_state_q <= pqc_pkg::PER_IDLE;
                end
            endcase
        end
    end

    // source edges between the two gate edges; one at the close still counts
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            per_count_q <= pqc_pkg::COUNT_RST;
        end else if (per_state_q == pqc_pkg::PER_WAIT_OPEN) begin
            per_count_q <= pqc_pkg::COUNT_RST;
        end else if (per_state_q == pqc_pkg::PER_COUNT && source_edge) begin
            per_count_q <= per_count_q + pqc_pkg::COUNT_ONE;
        end
    end

    // result register with a one-cycle valid strobe
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            period_q <= pqc_pkg::COUNT_RST;
            period_valid_q <= 1'b0;
        end else begin
            period_valid_q <= period_finish && !arm_i && !disarm_i;
            if (period_finish && !arm_i && !disarm_i) begin
                period_q <= source_edge ? per_count_q + pqc_pkg::COUNT_ONE
                                        : per_count_q;
            end
        end
    end

    assign period_o = period_q;
    assign period_valid_o = period_valid_q;

    // busy covers waiting for the opening edge and counting
    logic busy_q;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (per_state_q == pqc_pkg::PER_WAIT_OPEN) ||
                      (per_state_q == pqc_pkg::PER_COUNT && !gate_edge);
        end
    end

    assign period_busy_o = busy_q;

    // ------------------------------------------------------------
    // position counter with index reload
    // ------------------------------------------------------------
    logic [31:0] pos_q;
    logic pos_run;
    logic in_phase;
    logic reload_hit;

    assign pos_run = armed_q && pos_mode_q;

    // current quadrature phase against the programmed one
    always_comb begin
        in_phase = 1'b0;
        case (reload_phase_i)
            pqc_pkg::PH_A0_B0: in_phase = !a_level && !b_level;
            pqc_pkg::PH_A1_B0: in_phase = a_level && !b_level;
            pqc_pkg::PH_A1_B1: in_phase = a_level && b_level;
            pqc_pkg::PH_A0_B1: in_phase = !a_level && b_level;
            default: in_phase = 1'b0;
        endcase
    end

    // a step in the same cycle wins; that reload is dropped, as the step leaves the phase
    assign reload_hit = reload_en_i && z_level && in_phase &&
                        !step_up && !step_dn;

    // live count: cleared at arm, then steps, then index reloads
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pos_q <= pqc_pkg::COUNT_RST;
        end else if (arm_i) begin
            pos_q <= pqc_pkg::COUNT_RST; // counts are cumulative from the arm
        end else if (pos_run) begin
            if (step_up) begin
                pos_q <= pos_q + pqc_pkg::COUNT_ONE;
            end else if (step_dn) begin
                pos_q <= pos_q - pqc_pkg::COUNT_ONE;
            end else if (reload_hit) begin
                pos_q <= reload_value_i;
            end
        end
    end

    // the live count is visible at all times
    assign position_o = pos_q;

    // ------------------------------------------------------------
    // on-demand or sample-clocked read of the position
    // ------------------------------------------------------------
    logic [31:0] sample_q;
    logic sample_valid_q;
    logic take;

    // buffered mode samples on the clock, otherwise on request
    assign take = pos_run && (buffered_i ? sample_edge : read_req_i);

    // the valid strobe stands one cycle beside the new sample
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sample_q <= pqc_pkg::COUNT_RST;
            sample_valid_q <= 1'b0;
        end else begin
            sample_valid_q <= take;
            if (take) begin
                sample_q <= pos_q;
            end
        end
    end

    assign sample_o = sample_q;
    assign sample_valid_o = sample_valid_q;

endmodule

// ===== logic/quad_decoder.sv
// turns encoder edges into up and down count steps
`timescale 1ns/1ps
module quad_decoder (
    input wire pqc_pkg::decode_mode_t mode_i,
    edge_if.dst a,
    edge_if.dst b,
    output logic step_up_o,
    output logic step_dn_o
);

    // ------------------------------------------------------------
    // step selection per mode
    // ------------------------------------------------------------
    always_comb begin
        step_up_o = 1'b0;
        step_dn_o = 1'b0;
        case (mode_i)
            pqc_pkg::DEC_X1: begin
                step_up_o = a.rise && !b.level;
                step_dn_o = a.fall && !b.level;
            end
            pqc_pkg::DEC_X2: begin
                // both edges of a, direction from b
                step_up_o = (a.rise && !b.level) || (a.fall && b.level);
                step_dn_o = (a.rise && b.level) || (a.fall && !b.level);
            end
            pqc_pkg::DEC_X4: begin
                // every edge of a and b
                step_up_o = (a.rise && !b.level) || (a.fall && b.level) ||
                            (b.rise && a.level) || (b.fall && !a.level);
                step_dn_o = (a.rise && b.level) || (a.fall && !b.level) ||
                            (b.rise && !a.level) || (b.fall && a.level);
            end
            pqc_pkg::DEC_TWO_PULSE: begin
                // a rising counts up, b rising counts down
                step_up_o = a.rise && !b.rise;
                step_dn_o = b.rise && !a.rise;
            end
            default: begin
                step_up_o = 1'b0;
                step_dn_o = 1'b0;
            end
        endcase
    end

endmodule

// ===== testbench/encoder_model.sv
// behavioural quadrature and two-pulse encoder
`timescale 1ns/1ps
module encoder_model (
    input wire logic clk_sys_i,
    output logic a_o,
    output logic b_o
);
    int ph = 0;
    initial begin
        a_o = 1'b0;
        b_o = 1'b0;
    end
    // hold a level long enough for the synchroniser to accept it
    task automatic hold();
        repeat (4) @(negedge clk_sys_i);
    endtask
    // quarter cycle: +1 lets a lead b, -1 lets b lead a
    task automatic step(input int dir);
        ph = (ph + dir + 4) % 4;
        a_o = (ph == 1) || (ph == 2);
        b_o = (ph >= 2);
        hold();
    endtask
    // one pulse on a (ch 0) or on b (ch 1)
    task automatic pulse(input int ch);
        a_o = (ch == 0);
        b_o = (ch == 1);
        hold();
        a_o = 1'b0;
        b_o = 1'b0;
        hold();
    endtask
endmodule

// ===== testbench/period_quad_counter_properties.sv
// port assertions for the period and quadrature counter
`timescale 1ns/1ps
module period_quad_counter_properties (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic arm_i,
    input wire logic position_sel_i,
    input wire logic buffered_i,
    input wire logic read_req_i,
    input wire logic [31:0] reload_value_i,
    input wire logic armed_o,
    input wire logic period_busy_o,
    input wire logic [31:0] period_o,
    input wire logic period_valid_o,
    input wire logic [31:0] position_o,
    input wire logic [31:0] sample_o,
    input wire logic sample_valid_o
);
    // ------------------------------------------------------------
    // measurement kind latched at arm
    // ------------------------------------------------------------
    logic pos_mode_q;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pos_mode_q <= 1'b0;
        end else if (arm_i) begin
            pos_mode_q <= position_sel_i;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    arm_taken_a: assert property (arm_i |=> armed_o) else $error("arm not taken");
    period_end_a: assert property (
        period_valid_o |-> $past(armed_o) && $past(period_busy_o) && !armed_o)
        else $error("period result without measurement");
    period_pulse_a: assert property (period_valid_o |=> !period_valid_o)
        else $error("period valid too long");
    period_hold_a: assert property (!period_valid_o |-> $stable(period_o))
        else $error("period result moved");
    pos_clear_a: assert property (arm_i && position_sel_i |=> position_o == 32'h0)
        else $error("position not cleared");
    pos_idle_a: assert property (
        !$past(armed_o) && !$past(arm_i) |-> $stable(position_o))
        else $error("position moved unarmed");
    pos_step_a: assert property (
        $past(armed_o) && !$past(arm_i) && !$stable(position_o)
        |-> position_o == $past(position_o) + 32'h1 || position_o == $past(position_o) - 32'h1
        || position_o == reload_value_i) else $error("position jumped");
    read_demand_a: assert property (
        read_req_i && !buffered_i && armed_o && pos_mode_q
        |=> sample_valid_o && sample_o == $past(position_o))
        else $error("on-demand read wrong");
    sample_gate_a: assert property (
        sample_valid_o |-> $past(armed_o) && $past(pos_mode_q))
        else $error("sample while not armed");
endmodule

bind period_quad_counter period_quad_counter_properties period_quad_counter_properties_i (
    .clk_sys_i, .reset_i, .arm_i, .position_sel_i, .buffered_i, .read_req_i,
    .reload_value_i, .armed_o, .period_busy_o, .period_o, .period_valid_o,
    .position_o, .sample_o, .sample_valid_o
);

// ===== testbench/test_period_quad_counter.sv
// self-checking bench for the period and quadrature counter
`timescale 1ns/1ps
module test_period_quad_counter;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic enc_a, enc_b, enc_z = 1'b0, gate = 1'b0, source = 1'b0, sample_clk = 1'b0;
    logic arm = 1'b0, disarm = 1'b0, position_sel = 1'b0, gate_rising = 1'b1;
    logic source_rising = 1'b1, reload_en = 1'b0, buffered = 1'b0, read_req = 1'b0;
    logic sample_rising = 1'b1;
    logic [31:0] reload_value = 32'h0000_0100;
    pqc_pkg::reload_phase_t reload_phase = pqc_pkg::PH_A0_B0;
    pqc_pkg::decode_mode_t decode_mode = pqc_pkg::DEC_X1;
    logic armed_o, period_busy_o, period_valid_o, sample_valid_o;
    logic [31:0] period_o, position_o, sample_o, exp;
    int bad_count = 0, cmp_count = 0, cyc = 0, i, m;
    int kt[4] = '{1, 2, 4, 1};

    period_quad_counter period_quad_counter_i (.clk_sys_i, .reset_i, .enc_a_i(enc_a),
        .enc_b_i(enc_b), .enc_z_i(enc_z), .gate_i(gate), .source_i(source),
        .sample_clk_i(sample_clk), .arm_i(arm), .disarm_i(disarm),
        .position_sel_i(position_sel), .gate_rising_i(gate_rising),
        .source_rising_i(source_rising), .decode_mode_i(decode_mode),
        .reload_en_i(reload_en), .reload_phase_i(reload_phase),
        .reload_value_i(reload_value), .buffered_i(buffered), .sample_rising_i(sample_rising),
        .read_req_i(read_req), .armed_o, .period_busy_o, .period_o, .period_valid_o,
        .position_o, .sample_o, .sample_valid_o);
    encoder_model encoder_model_i (.clk_sys_i, .a_o(enc_a), .b_o(enc_b));

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // one-cycle arm pulse; the controlling side arms before counting
    task automatic do_arm(input logic sel);
        position_sel = sel;
        arm = 1'b1;
        tick(1);
        arm = 1'b0;
        tick(1);
    endtask
    // one period of n source pulses, g picks the active edge polarity
    task automatic period_run(input logic g, input int n);
        int j;
        gate_rising = g;
        source_rising = g;
        gate = g;
        tick(6);
        gate = !g;
        tick(6);
        do_arm(1'b0);
        gate = g;
        tick(6);
        check(period_busy_o, 1'b1);
        for (j = 0; j < n; j++) begin
            source = 1'b1;
            tick(4);
            source = 1'b0;
            tick(4);
        end
        gate = !g;
        tick(6);
        gate = g;
        for (j = 0; j < 12 && period_valid_o !== 1'b1; j++) tick(1);
        check(period_valid_o, 1'b1);
        check(period_o, n);
        tick(1);
        check(armed_o, 1'b0);
        gate = !g;
        tick(6);
        gate = g;
        tick(6);
        check(period_o, n);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(16);
        reset_i = 1'b0;
        check({armed_o, period_valid_o, sample_valid_o}, 32'h0);
        check(position_o, 32'h0);
        repeat (4) encoder_model_i.step(1);
        tick(4);
        check(position_o, 32'h0);
        period_run(1'b1, 5);
        period_run(1'b0, 3);
        // quadrature modes: two cycles forward, one back; two-pulse: three up, one down
        for (m = 0; m < 4; m++) begin
            decode_mode = pqc_pkg::decode_mode_t'(m);
            do_arm(1'b1);
            check(position_o, 32'h0);
            if (m == 3) begin
                repeat (3) encoder_model_i.pulse(0);
                encoder_model_i.pulse(1);
                exp = 32'h2;
            end else begin
                repeat (8) encoder_model_i.step(1);
                repeat (4) encoder_model_i.step(-1);
                exp = kt[m];
            end
            tick(4);
            check(position_o, exp);
            read_req = 1'b1;
            tick(1);
            read_req = 0;
            check(sample_valid_o, 1'b1);
            check(sample_o, exp);
        end
        // buffered: demand reads refused, sample clock edge taken
        buffered = 1'b1;
        read_req = 1'b1;
        tick(1);
        read_req = 1'b0;
        check(sample_valid_o, 1'b0);
        sample_clk = 1'b1;
        for (i = 0; i < 10 && sample_valid_o !== 1'b1; i++) tick(1);
        check(sample_valid_o, 1'b1);
        check(sample_o, exp);
        // falling sample clock edge, after one more count
        sample_rising = 1'b0;
        encoder_model_i.pulse(0);
        check(sample_valid_o, 1'b0);
        sample_clk = 1'b0;
        for (i = 0; i < 10 && sample_valid_o !== 1'b1; i++) tick(1);
        check(sample_valid_o, 1'b1);
        check(sample_o, exp + 32'h1);
        buffered = 1'b0;
        // index reload in phase a0 b0, the cycle after the up step that enters it
        decode_mode = pqc_pkg::DEC_X4;
        reload_en = 1'b1;
        do_arm(1'b1);
        repeat (3) encoder_model_i.step(1);
        enc_z = 1'b1;
        tick(4);
        check(position_o, 32'h3);
        encoder_model_i.step(1);
        tick(4);
        check(position_o, 32'h0000_0100);
        // leaving the reload phase with z still high: the step wins
        encoder_model_i.step(1);
        tick(4);
        check(position_o, 32'h0000_0101);
        // another reload phase and value
        reload_phase = pqc_pkg::PH_A1_B1;
        reload_value = 32'h0000_0200;
        tick(4);
        check(position_o, 32'h0000_0101);
        encoder_model_i.step(1);
        tick(4);
        check(position_o, 32'h0000_0200);
        enc_z = 1'b0;
        tick(4);
        disarm = 1'b1;
        tick(1);
        disarm = 1'b0;
        tick(1);
        check(armed_o, 1'b0);
        repeat (3) encoder_model_i.step(1);
        tick(4);
        check(position_o, 32'h0000_0200);
        test_done();
    end
endmodule
